// File: src/period_match_timer.sv
// Period match timer: instruction clock, prescaler, 8-bit count, period compare.
// Assumes a register master on the same clock with one-cycle strobes.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module period_match_timer
	import period_timer_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       arst_n_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic [7:0]      reg_rdata_out,
	output logic            irq_out
);
	typedef struct packed {
		logic [1:0] instr_div;
		logic [3:0] pre_cnt;
		logic [7:0] count;
		logic [7:0] period;
		control_t   ctl;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [7:0] rdata;
	} tmr_state_t;

	tmr_state_t s_q;
	tmr_state_t s_d;
	reg_req_t   req;
	logic       instr_tick;
	logic       pre_tick;
	logic       match;
	logic       post_pulse;
	logic [3:0] pre_last;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

	// Terminal count of the prescaler for a divider code
	function automatic logic [3:0] pre_limit(input logic [1:0] code);
		if (code[1]) begin
			pre_limit = PRE_LAST_DIV16;
		end else if (code[0]) begin
			pre_limit = PRE_LAST_DIV4;
		end else begin
			pre_limit = PRE_LAST_DIV1;
		end
	endfunction : pre_limit

	// Read mux; unmapped addresses return zero
	function automatic logic [7:0] read_mux(input tmr_state_t s, input logic [7:0] a);
		unique case (a)
			ADDR_TIMER_COUNT:   read_mux = s.count;
			ADDR_TIMER_CONTROL: read_mux = {1'b0, s.ctl};
			ADDR_PERIOD_VALUE:  read_mux = s.period;
			ADDR_FLAG_REG:      read_mux = s.flags;
			ADDR_MASK_REG:      read_mux = s.mask;
			default:            read_mux = 8'h00;
		endcase
	endfunction : read_mux

	// Instruction tick every fourth core clock, prescaler on top of it
	assign instr_tick = s_q.ctl.run && (s_q.instr_div == INSTR_DIV_LAST);
	assign pre_last   = pre_limit(s_q.ctl.in_div);
	assign pre_tick   = instr_tick && (s_q.pre_cnt >= pre_last);
	// Compare runs continuously; a match acts on the next increment
	assign match      = (s_q.count == s_q.period);

	postscaler u_post (
		.core_clk_in  (core_clk_in),
		.arst_n_in    (arst_n_in),
		.clear_in     (!s_q.ctl.run),
		.match_in     (pre_tick && match),
		.ratio_sel_in (s_q.ctl.out_div),
		.pulse_out    (post_pulse)
	);

	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		// Dividers
		if (!s_q.ctl.run) begin
			s_d.instr_div = 2'h0;
			s_d.pre_cnt   = 4'h0;
		end else begin
			s_d.instr_div = s_q.instr_div + 2'h1;
			if (instr_tick) begin
				s_d.pre_cnt = pre_tick ? 4'h0 : s_q.pre_cnt + 4'h1;
			end
		end
		// Count; a prescaler change mid-count applies at once, and a prescaler already at or past the new limit ticks on the next instruction tick
		if (!s_q.ctl.run) begin
			s_d.count = COUNT_RESET;
		end else if (req.wr && req.addr == ADDR_TIMER_COUNT) begin
			s_d.count = req.wdata;
		end else if (pre_tick) begin
			s_d.count = match ? COUNT_RESET : s_q.count + 8'h01;
		end
		// Other register writes; control does not touch the count
		if (req.wr) begin
			unique case (req.addr)
				ADDR_TIMER_CONTROL: s_d.ctl = control_t'(req.wdata[6:0] & CTL_WRITE_MASK[6:0]);
				ADDR_PERIOD_VALUE:  s_d.period = req.wdata;
				ADDR_FLAG_REG:      s_d.flags = s_q.flags & ~req.wdata;
				ADDR_MASK_REG:      s_d.mask = req.wdata;
				default:            s_d.flags = s_d.flags;
			endcase
		end
		// Hardware set wins over a same-cycle clear
		if (post_pulse) begin
			s_d.flags[FLAG_MATCH_BIT] = 1'b1;
		end
		if (req.rd) begin
			s_d.rdata = read_mux(s_q, req.addr);
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q        <= '0;
			s_q.count  <= COUNT_RESET;
			s_q.period <= PERIOD_RESET;
			s_q.ctl    <= control_t'(CONTROL_RESET[6:0]);
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_out = s_q.rdata;
	assign irq_out       = |(s_q.flags & s_q.mask);

	// Checks; bus strobes only qualify antecedents, consequents watch the design
	// Each property names its own clock, and each assertion its own reset, so no default clocking is used

	// Stopping holds the count and the prescaler at zero
	property p_stop_zero;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		!s_q.ctl.run
		|=> s_q.count == 8'h00 && s_q.pre_cnt == 4'h0;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("count not held while stopped");

	// A tick on a match returns the count to zero
	property p_wrap;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		pre_tick && match && !req.wr
		|=> s_q.count == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap on match");

	// A tick without a match advances the count by one
	property p_incr;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		pre_tick && !match && !req.wr
		|=> s_q.count == $past(s_q.count) + 8'h01;
	endproperty
	a_incr: assert property (p_incr) else $error("count did not advance");

	// Between ticks the count stands still
	property p_hold;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		s_q.ctl.run && !pre_tick && !req.wr
		|=> $stable(s_q.count);
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without a tick");

	// At 1:1 every instruction tick reaches the count
	property p_div1;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		s_q.ctl.run && s_q.ctl.in_div == 2'b00 && instr_tick
		|-> pre_tick;
	endproperty
	a_div1: assert property (p_div1) else $error("1:1 prescaler skipped");

	// A control write between ticks keeps the count
	property p_ctl_keep;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_TIMER_CONTROL && s_q.ctl.run && !pre_tick
		|=> s_q.count == $past(s_q.count);
	endproperty
	a_ctl_keep: assert property (p_ctl_keep) else $error("control write changed count");

	// The postscaler pulse raises the match flag
	property p_flag_set;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		post_pulse
		|=> s_q.flags[FLAG_MATCH_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("match flag not set");

	// Only a write to the flag register may drop the flag
	property p_flag_sticky;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		s_q.flags[FLAG_MATCH_BIT] && !(req.wr && req.addr == ADDR_FLAG_REG)
		|=> s_q.flags[FLAG_MATCH_BIT];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("match flag dropped");

	// Control reads back with bit seven as zero
	property p_read;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.rd && req.addr == ADDR_TIMER_CONTROL
		|=> reg_rdata_out == {1'b0, $past(s_q.ctl)};
	endproperty
	a_read: assert property (p_read) else $error("control readback wrong");

	// Instruction ticks are four core clocks apart
	property p_tick_gap;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		instr_tick
		|=> !instr_tick [*3];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("instruction ticks too close");

	// The first instruction tick lands on the fourth clock of running
	property p_tick_due;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		$rose(s_q.ctl.run) ##1 s_q.ctl.run [*3]
		|-> instr_tick;
	endproperty
	a_tick_due: assert property (p_tick_due) else $error("first instruction tick late");

	// The run bit follows bit two of a control write
	property p_run_bit;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_TIMER_CONTROL
		|=> s_q.ctl.run == $past(req.wdata[CTL_RUN_BIT]);
	endproperty
	a_run_bit: assert property (p_run_bit) else $error("run bit not written");

	// All control fields take the written value, bit seven dropped
	property p_ctl_fields;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_TIMER_CONTROL
		|=> {1'b0, s_q.ctl} == ($past(req.wdata) & CTL_WRITE_MASK);
	endproperty
	a_ctl_fields: assert property (p_ctl_fields) else $error("control fields not written");

	// At 1:4 no tick reaches the count before the fourth
	property p_div4_early;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		instr_tick && s_q.ctl.in_div == 2'b01 && s_q.pre_cnt < PRE_LAST_DIV4
		|-> !pre_tick;
	endproperty
	a_div4_early: assert property (p_div4_early) else $error("1:4 prescaler fired early");

	// At 1:16 no tick reaches the count before the sixteenth
	property p_div16_early;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		instr_tick && s_q.ctl.in_div[1] && s_q.pre_cnt < PRE_LAST_DIV16
		|-> !pre_tick;
	endproperty
	a_div16_early: assert property (p_div16_early) else $error("1:16 prescaler fired early");

	// A count write while running lands, even on a tick
	property p_count_write;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_TIMER_COUNT && s_q.ctl.run
		|=> s_q.count == $past(req.wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	// A count write while stopped is lost
	property p_stopped_write;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_TIMER_COUNT && !s_q.ctl.run
		|=> s_q.count == COUNT_RESET;
	endproperty
	a_stopped_write: assert property (p_stopped_write) else $error("stopped write landed");

	// Period writes land directly
	property p_period_write;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_PERIOD_VALUE
		|=> s_q.period == $past(req.wdata);
	endproperty
	a_period_write: assert property (p_period_write) else $error("period write lost");

	// Count reads return the value at the strobe
	property p_count_read;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.rd && req.addr == ADDR_TIMER_COUNT
		|=> reg_rdata_out == $past(s_q.count);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count readback wrong");

	// Period reads return the stored value
	property p_period_read;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.rd && req.addr == ADDR_PERIOD_VALUE
		|=> reg_rdata_out == $past(s_q.period);
	endproperty
	a_period_read: assert property (p_period_read) else $error("period readback wrong");

	// Read data stand only in the cycle after a strobe
	property p_rdata_idle;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		!req.rd
		|=> reg_rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

	// Writing one clears the flag when no pulse collides
	property p_flag_clear;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		req.wr && req.addr == ADDR_FLAG_REG && req.wdata[FLAG_MATCH_BIT] && !post_pulse
		|=> !s_q.flags[FLAG_MATCH_BIT];
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("match flag not cleared");

	// At 1:1 every match pulses the postscaler
	property p_post_single;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		pre_tick && match && s_q.ctl.out_div == 4'h0
		|=> post_pulse;
	endproperty
	a_post_single: assert property (p_post_single) else $error("1:1 postscaler skipped");

	// An unmasked flag drives the interrupt
	property p_irq_on;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		s_q.flags[FLAG_MATCH_BIT] && s_q.mask[FLAG_MATCH_BIT]
		|-> irq_out;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

	// With everything masked the interrupt stays low
	property p_mask_off;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		s_q.mask == 8'h00
		|-> !irq_out;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked interrupt raised");

	// Main scenarios worth seeing in coverage
	c_wrap: cover property (@(posedge core_clk_in) pre_tick && match);
	c_flag: cover property (@(posedge core_clk_in) post_pulse);
	c_irq: cover property (@(posedge core_clk_in) irq_out);
	c_div16: cover property (@(posedge core_clk_in) pre_tick && s_q.ctl.in_div[1]);
	c_run_write: cover property (@(posedge core_clk_in) req.wr && req.addr == ADDR_TIMER_COUNT && s_q.ctl.run);

endmodule : period_match_timer

// File: src/period_timer_pkg.sv
// Constants, register map and carrier types for the period match timer.
// Assumes a single 100 MHz core clock and an 8-bit register port.
package period_timer_pkg;

	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          INSTR_DIV         = 4;
	localparam logic [1:0]  INSTR_DIV_LAST    = 2'(INSTR_DIV - 1);

	// Register addresses
	localparam logic [7:0]  ADDR_TIMER_COUNT  = 8'h11;
	localparam logic [7:0]  ADDR_TIMER_CONTROL = 8'h12;
	localparam logic [7:0]  ADDR_PERIOD_VALUE = 8'h13;
	localparam logic [7:0]  ADDR_FLAG_REG     = 8'h14;
	localparam logic [7:0]  ADDR_MASK_REG     = 8'h15;

	// Control field positions
	localparam int          CTL_IDS_LSB       = 0;
	localparam int          CTL_RUN_BIT       = 2;
	localparam int          CTL_ODS_LSB       = 3;
	localparam logic [7:0]  CTL_WRITE_MASK    = 8'h7F;

	// Reset values
	localparam logic [7:0]  COUNT_RESET       = 8'h00;
	localparam logic [7:0]  PERIOD_RESET      = 8'hFF;
	localparam logic [7:0]  CONTROL_RESET     = 8'h00;

	// Flag bit of the period match event
	localparam int          FLAG_MATCH_BIT    = 0;

	// Prescaler terminal counts, code 00 / 01 / 1x
	localparam logic [3:0]  PRE_LAST_DIV1     = 4'h0;
	localparam logic [3:0]  PRE_LAST_DIV4     = 4'h3;
	localparam logic [3:0]  PRE_LAST_DIV16    = 4'hF;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [3:0] out_div;
		logic       run;
		logic [1:0] in_div;
	} control_t;

endpackage : period_timer_pkg

// File: src/postscaler.sv
// Match postscaler: counts period matches and pulses on the selected ratio.
// Assumes one core clock; match_in is a one-cycle pulse from the same domain.
`timescale 1ns/1ps
module postscaler
	import period_timer_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       clear_in,
	input  wire logic       match_in,
	input  wire logic [3:0] ratio_sel_in,
	output logic            pulse_out
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       pulse;
	} post_state_t;

	post_state_t s_q;
	post_state_t s_d;

	// Field n gives ratio n+1; the pulse lands on the (n+1)-th match after restart
	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (clear_in) begin
			s_d.cnt = 4'h0;
		end else if (match_in) begin
			if (s_q.cnt >= ratio_sel_in) begin
				s_d.cnt = 4'h0;
				s_d.pulse = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pulse_out = s_q.pulse;

	// Pulse on the match that completes the selected ratio
	property p_post_ratio;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		match_in && !clear_in && s_q.cnt == ratio_sel_in
		|=> pulse_out;
	endproperty
	a_post_ratio: assert property (p_post_ratio) else $error("postscaler missed its pulse");

	// Clearing drops both the count and any pending pulse
	property p_post_clear;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		clear_in
		|=> s_q.cnt == 4'h0 && !pulse_out;
	endproperty
	a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared");

	// Matches short of the ratio only advance the count
	property p_post_count;
		@(posedge core_clk_in) disable iff (!arst_n_in)
		match_in && !clear_in && s_q.cnt < ratio_sel_in
		|=> s_q.cnt == $past(s_q.cnt) + 4'h1 && !pulse_out;
	endproperty
	a_post_count: assert property (p_post_count) else $error("postscaler count stuck");

endmodule : postscaler

// File: verif/test_period_match_timer.sv
// Self-checking bench for the period match timer: register tasks and timed checks.
// Assumes read data one cycle after the strobe and a level interrupt output.
`timescale 1ns/1ps
module test_period_match_timer
	import period_timer_pkg::*;
;
	logic        core_clk_in;
	logic        arst_n_in;
	logic [7:0]  reg_addr_in;
	logic [7:0]  reg_wdata_in;
	logic        reg_wr_in;
	logic        reg_rd_in;
	logic [7:0]  reg_rdata_out;
	logic        irq_out;
	int          mismatches;
	int          comparisons;
	int          cyc;
	int          t0;
	int          t1;
	logic [7:0]  v;
	logic [7:0]  ctls [5] = '{8'h04, 8'h0D, 8'h16, 8'h7F, 8'h7C};
	int          exps [5] = '{16, 128, 768, 4096, 256};

	period_match_timer period_match_timer_i (
		.core_clk_in   (core_clk_in),
		.arst_n_in     (arst_n_in),
		.reg_addr_in   (reg_addr_in),
		.reg_wdata_in  (reg_wdata_in),
		.reg_wr_in     (reg_wr_in),
		.reg_rd_in     (reg_rd_in),
		.reg_rdata_out (reg_rdata_out),
		.irq_out       (irq_out)
	);

	// Free-running 100 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	// Hang guard, well above the longest measurement sequence
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in    <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in   <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask : rd

	// Bounded wait for the interrupt, returns the cycle it was seen
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		do begin
			@(posedge core_clk_in);
			#1;
			n++;
		end while (irq_out !== 1'b1 && n < 9000);
		check("irq_seen", 16'(irq_out), 16'h0001);
		t = cyc;
	endtask : wait_irq

	// Rise-to-rise interval after the phase has settled
	task automatic measure(input logic [7:0] ctl, input int exp);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		wr(ADDR_TIMER_CONTROL, ctl);
		wait_irq(t0);
		wr(ADDR_FLAG_REG, 8'h01);
		wait_irq(t0);
		wr(ADDR_FLAG_REG, 8'h01);
		wait_irq(t1);
		wr(ADDR_FLAG_REG, 8'h01);
		check("interval", 16'(t1 - t0), 16'(exp));
	endtask : measure

	task automatic reset_checks();
		rd(ADDR_TIMER_COUNT, v);
		check("count_rst", 16'(v), 16'(COUNT_RESET));
		rd(ADDR_PERIOD_VALUE, v);
		check("period_rst", 16'(v), 16'(PERIOD_RESET));
		rd(ADDR_TIMER_CONTROL, v);
		check("control_rst", 16'(v), 16'(CONTROL_RESET));
		rd(ADDR_FLAG_REG, v);
		check("flag_rst", 16'(v), 16'h0000);
		check("irq_rst", 16'(irq_out), 16'h0000);
	endtask : reset_checks

	// Main sequence; the postscaler phase is reset by stopping before each case
	initial begin
		{arst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= '0;
		{mismatches, comparisons} = '0;
		repeat (6) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		reset_checks();
		wr(8'h20, 8'hA5);
		rd(8'h20, v);
		check("unmapped", 16'(v), 16'h0000);
		wr(ADDR_TIMER_COUNT, 8'h55);
		rd(ADDR_TIMER_COUNT, v);
		check("stopped_write", 16'(v), 16'h0000);
		wr(ADDR_TIMER_CONTROL, 8'hFF);
		rd(ADDR_TIMER_CONTROL, v);
		check("control_rw", 16'(v), 16'h007F);
		wr(ADDR_TIMER_CONTROL, 8'h00);
		rd(ADDR_TIMER_COUNT, v);
		check("stopped_count", 16'(v), 16'h0000);
		wr(ADDR_PERIOD_VALUE, 8'h03);
		rd(ADDR_PERIOD_VALUE, v);
		check("period_rw", 16'(v), 16'h0003);
		wr(ADDR_MASK_REG, 8'h01);
		for (int i = 0; i < 5; i++)
			measure(ctls[i], exps[i]);
		wait_irq(t0);
		wr(ADDR_MASK_REG, 8'h00);
		#1;
		check("irq_masked", 16'(irq_out), 16'h0000);
		// Stop first, so no later pulse can refresh the flag
		wr(ADDR_TIMER_CONTROL, 8'h00);
		repeat (600) @(posedge core_clk_in);
		rd(ADDR_FLAG_REG, v);
		check("flag_sticky", 16'(v), 16'h0001);
		wr(ADDR_MASK_REG, 8'h01);
		#1;
		check("irq_unmasked", 16'(irq_out), 16'h0001);
		wr(ADDR_FLAG_REG, 8'h01);
		#1;
		check("irq_cleared", 16'(irq_out), 16'h0000);
		wr(ADDR_PERIOD_VALUE, 8'hFF);
		wr(ADDR_TIMER_CONTROL, 8'h06);
		wr(ADDR_TIMER_COUNT, 8'h40);
		rd(ADDR_TIMER_COUNT, v);
		check("running_write", 16'(v >= 8'h40 && v <= 8'h41), 16'h0001);
		wr(ADDR_TIMER_CONTROL, 8'h7E);
		rd(ADDR_TIMER_COUNT, v);
		check("count_kept", 16'(v >= 8'h40 && v <= 8'h41), 16'h0001);
		@(posedge core_clk_in);
		arst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		reset_checks();
		complete_run();
	end
endmodule : test_period_match_timer
